// ### hw/cfm_pkg.sv
package cfm_pkg;
  // channel and counter sizing
  localparam int          NUM_CH       = 8;
  localparam int          OC_CH        = 6;
  localparam int          OC_CNT_W     = 7;
  // overcurrent qualification window, counted in CLK_SYS cycles
  localparam logic [6:0]  OC_QUAL_CYC  = 7'h40;
  localparam logic [6:0]  OC_CNT_RST   = 7'h00;
  // register map
  localparam logic [11:0] ADR_CTRL     = 12'h000;
  localparam logic [11:0] ADR_STATUS   = 12'h004;
  localparam logic [11:0] ADR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADR_IRQ_EN   = 12'h00C;
  localparam logic [11:0] ADR_IRQ_CLR  = 12'h010;
  localparam logic [11:0] ADR_FAULTS   = 12'h014;
  // control register field positions and reset value
  localparam int          CTRL_SLEEP   = 0;
  localparam int          CTRL_FE_EN   = 1;
  localparam int          CTRL_PAIR_EN = 2;
  localparam int          CTRL_BL_EN   = 3;
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  // interrupt status bit positions
  localparam int          IRQ_UV       = 0;
  localparam int          IRQ_OC_LATCH = 1;
  localparam int          IRQ_THERMAL  = 2;
  localparam int          IRQ_OV       = 3;
  localparam int          IRQ_BL_OC    = 4;
  localparam logic [4:0]  IRQ_RST      = 5'h00;
  localparam logic [7:0]  OV_RST       = 8'h00;
  // state of the shared shutdown latch
  typedef enum logic [1:0] {
    CFM_RUN   = 2'b01,
    CFM_LATCH = 2'b10
  } cfm_state_t;
endpackage : cfm_pkg

// ### hw/cfm_fault_manager.sv
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser for asynchronous comparator and pin levels
module cfm_sync2 (
  input  wire logic CLK_SYS,
  input  wire logic SRST,
  input  wire logic d,
  output var  logic q
);
  logic meta_q;
  // first flop feeds only the second
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // cfm_sync2

// per-channel overcurrent qualifier for channels one to six
module cfm_oc_qual (
  input  wire logic CLK_SYS,
  input  wire logic SRST,
  input  wire logic cond,
  output var  logic trip
);
  import cfm_pkg::*;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  // restart whenever the condition drops so short glitches never add up
  assign cnt_d = !cond ? OC_CNT_RST :
                 (cnt_q == OC_QUAL_CYC) ? cnt_q : cnt_q + 7'h01;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) cnt_q <= OC_CNT_RST;
    else      cnt_q <= cnt_d;
  end
  assign trip = cond && (cnt_q == OC_QUAL_CYC);
endmodule // cfm_oc_qual

module cfm_fault_manager (
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic [5:0]  OC_OVER_LIMIT,
  input  wire logic [5:0]  OC_OUT_LOW,
  input  wire logic        BL_OVER_LIMIT,
  input  wire logic        CH8_OUT_LOW,
  input  wire logic        REF_OUT_LOW,
  input  wire logic [7:0]  OV_FEEDBACK_HIGH,
  input  wire logic        UNDERVOLTAGE_LOCKOUT,
  input  wire logic        THERMAL_CUTOUT,
  output var  logic [7:0]  CH_RAMP_SECONDARY,
  output var  logic [7:0]  CH_SWITCH_ENABLE,
  output var  logic        ALL_SHUTDOWN,
  input  wire logic        IMAGER_SEQUENCE_SELECT,
  output var  logic        IRQ
);
  import cfm_pkg::*;

  logic [3:0]  ctrl_q;
  logic [4:0]  irq_stat_q;
  logic [4:0]  irq_en_q;
  logic [7:0]  ov_q;
  logic        bl_ov_q;
  logic        seq_sel_q;
  logic [31:0] prdata_q;
  logic [3:0]  ctrl_prev_q;
  logic        uv_prev_q;
  cfm_state_t  state_q;
  cfm_state_t  state_d;
  logic        thermal_lat_q;
  logic        c8ref_cause_q;
  logic [4:0]  irq_prev_q;

  // synchronised comparator flags
  logic [5:0] oc_lim_s;
  logic [5:0] oc_low_s;
  logic [7:0] ov_s;
  logic [5:0] oc_trip;
  logic       bl_oc_s;
  logic       ch8_low_s;
  logic       ref_low_s;
  logic       uv_s;
  logic       tsd_s;
  logic       seq_s;
  wire  [5:0] oc_cond = oc_lim_s & oc_low_s; // limit and low output together

  // every analog flag crosses two flops before use
  genvar gi;
  generate
    for (gi = 0; gi < OC_CH; gi++) begin : g_oc
      cfm_sync2 u_lim (.CLK_SYS(CLK_SYS), .SRST(SRST),
                       .d(OC_OVER_LIMIT[gi]), .q(oc_lim_s[gi]));
      cfm_sync2 u_low (.CLK_SYS(CLK_SYS), .SRST(SRST),
                       .d(OC_OUT_LOW[gi]), .q(oc_low_s[gi]));
      cfm_oc_qual u_q (.CLK_SYS(CLK_SYS), .SRST(SRST),
                       .cond(oc_cond[gi]),
                       .trip(oc_trip[gi]));
    end
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ov
      cfm_sync2 u_ov (.CLK_SYS(CLK_SYS), .SRST(SRST),
                      .d(OV_FEEDBACK_HIGH[gi]), .q(ov_s[gi]));
    end
  endgenerate
  cfm_sync2 u_bl  (.CLK_SYS(CLK_SYS), .SRST(SRST),
                   .d(BL_OVER_LIMIT), .q(bl_oc_s));
  cfm_sync2 u_c8  (.CLK_SYS(CLK_SYS), .SRST(SRST),
                   .d(CH8_OUT_LOW), .q(ch8_low_s));
  cfm_sync2 u_ref (.CLK_SYS(CLK_SYS), .SRST(SRST),
                   .d(REF_OUT_LOW), .q(ref_low_s));
  cfm_sync2 u_uv  (.CLK_SYS(CLK_SYS), .SRST(SRST),
                   .d(UNDERVOLTAGE_LOCKOUT), .q(uv_s));
  cfm_sync2 u_tsd (.CLK_SYS(CLK_SYS), .SRST(SRST),
                   .d(THERMAL_CUTOUT), .q(tsd_s));
  cfm_sync2 u_seq (.CLK_SYS(CLK_SYS), .SRST(SRST),
                   .d(IMAGER_SEQUENCE_SELECT), .q(seq_s));

  // apb decode; the slave always answers in the access cycle
  wire apb_acc  = PSEL && PENABLE;
  wire apb_wr   = apb_acc && PWRITE;
  wire apb_rd   = apb_acc && !PWRITE;
  wire hit_ctrl = (PADDR == ADR_CTRL);
  wire hit_en   = (PADDR == ADR_IRQ_EN);
  wire hit_clr  = (PADDR == ADR_IRQ_CLR);
  wire hit_any  = hit_ctrl || hit_en || hit_clr || (PADDR == ADR_STATUS) ||
                  (PADDR == ADR_IRQ_STAT) || (PADDR == ADR_FAULTS);

  // control bits standing in for the host pins
  wire active_low_sleep        = ctrl_q[CTRL_SLEEP];
  wire frontend_channel_enable = ctrl_q[CTRL_FE_EN];
  wire imager_pair_enable      = ctrl_q[CTRL_PAIR_EN];
  wire backlight_enable        = ctrl_q[CTRL_BL_EN];

  // rising edges of the host enables
  wire rise_sleep = active_low_sleep && !ctrl_prev_q[CTRL_SLEEP];
  wire rise_fe    = frontend_channel_enable && !ctrl_prev_q[CTRL_FE_EN];
  wire rise_pair  = imager_pair_enable && !ctrl_prev_q[CTRL_PAIR_EN];
  wire rise_bl    = backlight_enable && !ctrl_prev_q[CTRL_BL_EN];
  // supply reapplied: lockout flag falls, i.e. supply back above 1.4 V
  wire resupply   = uv_prev_q && !uv_s;

  // clear events for the different latched faults
  wire clr_oc16   = rise_sleep || rise_fe || rise_pair || resupply;
  wire clr_c8ref  = rise_sleep || rise_fe || resupply;
  wire clr_tsd    = rise_sleep || rise_fe || rise_pair || resupply;

  // latch causes; ch8 and reference clear narrower than ch1-6
  wire trip_oc16  = |oc_trip;
  wire trip_c8ref = ch8_low_s || ref_low_s;
  wire uv_kill    = active_low_sleep && uv_s;

  // a ch8 or reference cause in the latch needs the narrower clear set
  wire lat_clear = (state_q == CFM_LATCH) &&
                   (c8ref_cause_q ? clr_c8ref : clr_oc16);

  // the latch leaves only on a clear that matches its causes
  assign state_d = (trip_oc16 || trip_c8ref) ? CFM_LATCH :
                   lat_clear ? CFM_RUN : state_q;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) state_q <= CFM_RUN;
    else      state_q <= state_d;
  end

  // remembers a ch8 or reference cause until the latch is left
  always_ff @(posedge CLK_SYS) begin
    if (SRST)            c8ref_cause_q <= 1'b0;
    else if (trip_c8ref) c8ref_cause_q <= 1'b1;
    else if (lat_clear)  c8ref_cause_q <= 1'b0;
  end

  // thermal latch: set wins over a simultaneous restart event
  always_ff @(posedge CLK_SYS) begin
    if (SRST)        thermal_lat_q <= 1'b0;
    else if (tsd_s)  thermal_lat_q <= 1'b1;
    else if (clr_tsd) thermal_lat_q <= 1'b0;
  end

  // led overvoltage holds until backlight enable rises
  always_ff @(posedge CLK_SYS) begin
    if (SRST)               bl_ov_q <= 1'b0;
    else if (ov_s[6])       bl_ov_q <= 1'b1;
    else if (rise_bl)       bl_ov_q <= 1'b0;
  end

  // ch1-6 and ch8 overvoltage simply follow the comparator
  always_comb begin
    ov_q = ov_s;
    ov_q[6] = bl_ov_q;
  end

  // host-side edge memory and sequence select sample
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ctrl_prev_q <= CTRL_RST;
      uv_prev_q   <= 1'b0;
      seq_sel_q   <= 1'b0;
    end else begin
      ctrl_prev_q <= ctrl_q;
      uv_prev_q   <= uv_s;
      seq_sel_q   <= seq_s;
    end
  end

  // shutdown: latched fault, thermal, undervoltage or sleep
  assign ALL_SHUTDOWN = (state_q == CFM_LATCH) || thermal_lat_q ||
                        uv_kill || !active_low_sleep;

  // per-channel switch gating
  always_comb begin
    CH_SWITCH_ENABLE    = {8{!ALL_SHUTDOWN}} & ~ov_q;
    CH_SWITCH_ENABLE[3] = CH_SWITCH_ENABLE[3] && frontend_channel_enable;
    CH_SWITCH_ENABLE[4] = CH_SWITCH_ENABLE[4] && imager_pair_enable;
    CH_SWITCH_ENABLE[5] = CH_SWITCH_ENABLE[5] && imager_pair_enable;
    // led switch drops while over limit, returns when current falls
    CH_SWITCH_ENABLE[6] = CH_SWITCH_ENABLE[6] && backlight_enable &&
                          !bl_oc_s;
  end

  // ramp source selection; 1 = secondary soft-start source
  always_comb begin
    CH_RAMP_SECONDARY    = 8'h00;
    CH_RAMP_SECONDARY[4] = seq_sel_q;
    CH_RAMP_SECONDARY[5] = 1'b1;
  end

  // sticky events are rising conditions, so a standing fault can be cleared
  wire [4:0] irq_lvl = {bl_oc_s, |ov_q, thermal_lat_q,
                        state_q == CFM_LATCH, uv_kill};
  wire [4:0] irq_evt = irq_lvl & ~irq_prev_q;
  wire [4:0] irq_clr = (apb_wr && hit_clr) ? PWDATA[4:0] : 5'h00;

  // event set wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      irq_stat_q <= IRQ_RST;
      irq_prev_q <= IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      irq_prev_q <= irq_lvl;
    end
  end

  // writable registers
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ctrl_q   <= CTRL_RST;
      irq_en_q <= IRQ_RST;
    end else begin
      if (apb_wr && hit_ctrl) ctrl_q   <= PWDATA[3:0];
      if (apb_wr && hit_en)   irq_en_q <= PWDATA[4:0];
    end
  end

  // read mux, registered for the data output
  wire [31:0] rd_mux =
    (PADDR == ADR_CTRL)     ? {28'h0, ctrl_q} :
    (PADDR == ADR_STATUS)   ? {24'h0, 4'h0, thermal_lat_q, uv_kill,
                               state_q == CFM_LATCH, seq_sel_q} :
    (PADDR == ADR_IRQ_STAT) ? {27'h0, irq_stat_q} :
    (PADDR == ADR_IRQ_EN)   ? {27'h0, irq_en_q} :
    (PADDR == ADR_FAULTS)   ? {16'h0, ov_q, 2'h0, oc_trip} :
    32'h0;

  always_ff @(posedge CLK_SYS) begin
    if (SRST)             prdata_q <= 32'h0000_0000;
    else if (PSEL && !PENABLE) prdata_q <= rd_mux;
  end

  assign PRDATA  = apb_rd ? prdata_q : 32'h0000_0000;
  assign PREADY  = 1'b1;
  assign PSLVERR = apb_acc && !hit_any;
  assign IRQ     = |(irq_stat_q & irq_en_q);

  // latched ch1-6 overcurrent takes everything down next cycle
  oc_latch_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    trip_oc16 |=> ALL_SHUTDOWN && CH_SWITCH_ENABLE == 8'h00)
    else $error("overcurrent did not latch all channels off");
  // qualifier needs a full window of the condition
  oc_qual_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(trip_oc16) |-> ($past(oc_cond, 64) & oc_trip) == oc_trip)
    else $error("overcurrent tripped early");
  // a dropped condition restarts the window, so no trip right after it
  oc_cnt_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (oc_trip & ~$past(oc_cond)) == 6'h00)
    else $error("overcurrent trip without condition");
  uv_kill_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (active_low_sleep && uv_s) |-> CH_SWITCH_ENABLE == 8'h00)
    else $error("undervoltage did not shut down");
  ramp_sel_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CH_RAMP_SECONDARY[3:0] == 4'h0 &&
    CH_RAMP_SECONDARY[4] == seq_sel_q && CH_RAMP_SECONDARY[5])
    else $error("ramp source selection wrong");
  ov_local_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    ov_s[0] && !ov_s[1] && !ALL_SHUTDOWN |->
    !CH_SWITCH_ENABLE[0] && CH_SWITCH_ENABLE[1])
    else $error("overvoltage not local to its channel");
  led_oc_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    bl_oc_s |-> !CH_SWITCH_ENABLE[6])
    else $error("led switch on during overcurrent");
  led_ov_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    bl_ov_q && !ov_s[6] && !rise_bl |=> bl_ov_q)
    else $error("led overvoltage released without enable rise");
  c8_latch_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    trip_c8ref |=> state_q == CFM_LATCH)
    else $error("ch8 or reference fault did not latch");
  tsd_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    thermal_lat_q && !tsd_s && !clr_tsd |=> thermal_lat_q)
    else $error("thermal latch released without restart event");
endmodule // cfm_fault_manager

`default_nettype wire

// ### test/cfm_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// host side: bus master whose control word plays the sleep and enables
module cfm_host_model
  import cfm_pkg::*;
(
  input  wire logic        CLK_SYS,
  output var  logic        PSEL,
  output var  logic        PENABLE,
  output var  logic        PWRITE,
  output var  logic [11:0] PADDR,
  output var  logic [31:0] PWDATA,
  input  wire logic        PREADY
);
  import cfm_pkg::*;
  logic [3:0] ctrl_q;

  // idle bus at time zero
  initial begin
    PSEL    = 1'b0;
    PENABLE = 1'b0;
    PWRITE  = 1'b0;
    PADDR   = 12'h000;
    PWDATA  = 32'h0000_0000;
    ctrl_q  = CTRL_RST;
  end

  // one transfer, request held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // pins hold their level between calls, like real host outputs
  task automatic set_ctrl(input logic [3:0] v);
    ctrl_q = v;
    xfer(1'b1, ADR_CTRL, {28'h0000000, v});
  endtask

  // low then high again: releases a latched fault, as a supply restart also does
  task automatic edge_ctrl(input logic [3:0] m);
    xfer(1'b1, ADR_CTRL, {28'h0000000, ctrl_q & ~m});
    xfer(1'b1, ADR_CTRL, {28'h0000000, ctrl_q});
  endtask
endmodule // cfm_host_model

`default_nettype wire

// ### test/cfm_fault_manager_test.sv
`timescale 1ns/100ps
`default_nettype none

module cfm_fault_manager_test;
  import cfm_pkg::*;
  logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  oc_lim, oc_low;
  logic [7:0]  ov_fb, ramp_sec, sw_en;
  logic        bl_lim, ch8_low, ref_low, uv, thermal, seq_sel, all_sd, irq;
  logic [32:0] exp_q[$];
  int          n_errors = 0;
  int          n_compared = 0;
  int          ch;

  cfm_fault_manager i_dut (.CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .OC_OVER_LIMIT(oc_lim), .OC_OUT_LOW(oc_low), .BL_OVER_LIMIT(bl_lim),
    .CH8_OUT_LOW(ch8_low), .REF_OUT_LOW(ref_low), .OV_FEEDBACK_HIGH(ov_fb),
    .UNDERVOLTAGE_LOCKOUT(uv), .THERMAL_CUTOUT(thermal),
    .CH_RAMP_SECONDARY(ramp_sec), .CH_SWITCH_ENABLE(sw_en),
    .ALL_SHUTDOWN(all_sd), .IMAGER_SEQUENCE_SELECT(seq_sel), .IRQ(irq));

  cfm_host_model i_host (.CLK_SYS(clk_sys), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // read results are paired with the oldest note at the access edge
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
  end

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    i_host.xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d);
  endtask

  // comparator levels cross two flops; leave margin, then step off edge
  task automatic settle;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  task automatic sd_is(input logic e);
    chk({32'h0, all_sd}, {32'h0, e});
  endtask

  task automatic sw_is(input logic [7:0] e);
    chk({25'h0, sw_en}, {25'h0, e});
  endtask

  task automatic irq_is(input logic e);
    chk({32'h0, irq}, {32'h0, e});
  endtask

  task automatic pulse_uv;
    @(posedge clk_sys);
    uv <= 1'b1;
    settle;
    sd_is(1'b1);
    @(posedge clk_sys);
    uv <= 1'b0;
  endtask

  // a hang ends the run through the same verdict
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    finish_test;
  end

  initial begin
    {oc_lim, oc_low, ov_fb, bl_lim, ch8_low, ref_low} = '0;
    {uv, thermal, seq_sel} = 3'h0;
    srst = 1'b1;
    void'($urandom(32'h2eb6));
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    sd_is(1'b1);
    sw_is(8'h00);
    rd(ADR_CTRL, 33'h0);
    rd(ADR_IRQ_STAT, 33'h0);
    rd(ADR_IRQ_EN, 33'h0);
    rd(12'hFFC, {1'b1, 32'h0});
    wr(ADR_FAULTS, 32'hFFFF_FFFF);
    rd(ADR_FAULTS, 33'h0);
    // ramp source for both select levels
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      seq_sel <= i[0];
      settle;
      chk({25'h0, ramp_sec}, {27'h1, i[0], 4'h0});
    end
    i_host.set_ctrl(4'hF);
    wr(ADR_IRQ_EN, 32'h1F);
    settle;
    sd_is(1'b0);
    sw_is(8'hFF);
    // overcurrent: limit alone, short window, then full window
    ch = $urandom_range(5, 0);
    @(posedge clk_sys);
    oc_lim[ch] <= 1'b1;
    repeat (100) @(posedge clk_sys);
    oc_low[ch] <= 1'b1;
    repeat (50) @(posedge clk_sys);
    oc_low[ch] <= 1'b0;
    settle;
    sd_is(1'b0);
    @(posedge clk_sys);
    oc_low[ch] <= 1'b1;
    repeat (80) @(posedge clk_sys);
    #1;
    sd_is(1'b1);
    irq_is(1'b1);
    rd(ADR_FAULTS, {1'b0, 32'h1 << ch});
    rd(ADR_IRQ_STAT, 33'h02);
    @(posedge clk_sys);
    oc_lim[ch] <= 1'b0;
    oc_low[ch] <= 1'b0;
    settle;
    sd_is(1'b1);
    wr(ADR_IRQ_CLR, 32'h1F);
    settle;
    irq_is(1'b0);
    i_host.edge_ctrl(4'h4);
    settle;
    sd_is(1'b0);
    // ch8 and reference faults, each released another way
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      if (k == 1) ref_low <= 1'b1;
      else ch8_low <= 1'b1;
      settle;
      sd_is(1'b1);
      @(posedge clk_sys);
      ch8_low <= 1'b0;
      ref_low <= 1'b0;
      settle;
      sd_is(1'b1);
      if (k == 0) begin
        i_host.edge_ctrl(4'h4);
        settle;
        sd_is(1'b1);
      end
      if (k == 2) pulse_uv;
      else i_host.edge_ctrl(k == 0 ? 4'h2 : 4'h1);
      settle;
      sd_is(1'b0);
    end
    // undervoltage while awake with no latch standing
    pulse_uv;
    settle;
    sd_is(1'b0);
    // led overcurrent restores itself
    @(posedge clk_sys);
    bl_lim <= 1'b1;
    settle;
    sw_is(8'hBF);
    @(posedge clk_sys);
    bl_lim <= 1'b0;
    settle;
    sw_is(8'hFF);
    // overvoltage on each channel in turn
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_sys);
      ov_fb[c] <= 1'b1;
      settle;
      sw_is(~(8'h01 << c));
      @(posedge clk_sys);
      ov_fb[c] <= 1'b0;
      settle;
      if (c == 6) begin
        sw_is(8'hBF);
        i_host.edge_ctrl(4'h8);
        settle;
      end
      sw_is(8'hFF);
    end
    // thermal cutout with its interrupt masked, then unmasked
    wr(ADR_IRQ_CLR, 32'h1F);
    wr(ADR_IRQ_EN, 32'h1B);
    @(posedge clk_sys);
    thermal <= 1'b1;
    settle;
    sd_is(1'b1);
    irq_is(1'b0);
    rd(ADR_IRQ_STAT, 33'h04);
    @(posedge clk_sys);
    thermal <= 1'b0;
    settle;
    sd_is(1'b1);
    wr(ADR_IRQ_EN, 32'h1F);
    settle;
    irq_is(1'b1);
    wr(ADR_IRQ_CLR, 32'h04);
    settle;
    irq_is(1'b0);
    i_host.edge_ctrl(4'h1);
    settle;
    sd_is(1'b0);
    finish_test;
  end
endmodule // cfm_fault_manager_test

`default_nettype wire
